// [inc/arca_pkg.sv]
// Package of constants and types for the result coding accumulator
package arca_pkg;
	// -----------------------------------------------------------------
	// Widths and limits
	// -----------------------------------------------------------------
	localparam int ARCA_RES_W_14 = 14;
	localparam int ARCA_RES_W_12 = 12;
	localparam int ARCA_ACC_W = 24;
	localparam int ARCA_CNT_W = 11;
	localparam logic [10:0] ARCA_MAX_SAMPLES = 11'h400;
	localparam int ARCA_LEN_W = 5;
	localparam int ARCA_FIFO_DEPTH = 8;
	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [23:0] ARCA_ACC_RST = 24'h000000;
	localparam logic [10:0] ARCA_CNT_RST = 11'h000;
	localparam logic [4:0] ARCA_LEN_RST = 5'h00;
	localparam logic [1:0] ARCA_SYNC_RST = 2'h0;

	typedef enum logic [1:0] {
		ARCA_IDLE,
		ARCA_LOAD,
		ARCA_SHIFT
	} arca_state_e;

	// Transmitted width: base width plus ceil(log2(samples)), one extra bit per doubling
	function automatic logic [4:0] arca_tx_len(input logic [10:0] n, input logic wide);
		logic [4:0] ext;
		logic [10:0] m;
		ext = 5'h00;
		m = n - 11'h001;
		for (int b = 0; b < 11; b++) begin
			if (m[b]) begin
				ext = 5'(b + 1);
			end
		end
		arca_tx_len = (wide ? 5'(ARCA_RES_W_14) : 5'(ARCA_RES_W_12)) + ext;
	endfunction
endpackage

// [logic/arca_core.sv]
// Result coding, accumulation and serial output of the converter
`timescale 1ns/10ps
module arca_core
	import arca_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Variant strap, high for 14-bit results
	input wire logic i_wide_res,
	// Converter core side, signed raw value wider than the code
	input wire logic i_raw_valid,
	input wire logic [15:0] i_raw_value,
	output logic o_raw_ready,
	// Serial link pins
	input wire logic i_convert_strobe,
	input wire logic i_sclk,
	output logic o_sdo,
	output logic o_sdo_oe,
	// Status
	output logic o_acc_count_max
);
	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	logic [1:0] cnv_sync_q;
	logic [1:0] sclk_sync_q;
	logic cnv_q;
	logic sclk_q;
	logic cnv_rise;
	logic sclk_rise;
	logic sclk_fall;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnv_sync_q <= ARCA_SYNC_RST;
			sclk_sync_q <= ARCA_SYNC_RST;
			cnv_q <= 1'b0;
			sclk_q <= 1'b0;
		end else begin
			cnv_sync_q <= {cnv_sync_q[0], i_convert_strobe};
			sclk_sync_q <= {sclk_sync_q[0], i_sclk};
			cnv_q <= cnv_sync_q[1];
			sclk_q <= sclk_sync_q[1];
		end
	end

	assign cnv_rise = cnv_sync_q[1] && !cnv_q;
	assign sclk_rise = sclk_sync_q[1] && !sclk_q;
	assign sclk_fall = !sclk_sync_q[1] && sclk_q;

	// -----------------------------------------------------------------
	// Wide strap, synchronised then caught once after reset release
	// -----------------------------------------------------------------
	logic [1:0] wide_sync_q;
	logic [1:0] strap_age_q;
	logic wide_q;

	// Strap is a pin, so it passes two flops before it is caught
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wide_sync_q <= ARCA_SYNC_RST;
			strap_age_q <= ARCA_SYNC_RST;
			wide_q <= 1'b1;
		end else begin
			wide_sync_q <= {wide_sync_q[0], i_wide_res};
			// Age saturates so a later strap change is ignored
			if (strap_age_q != 2'h3) begin
				strap_age_q <= strap_age_q + 2'h1;
			end
			if (strap_age_q == 2'h2) begin
				wide_q <= wide_sync_q[1];
			end
		end
	end

	// -----------------------------------------------------------------
	// Coding and clamping
	// -----------------------------------------------------------------
	// Raw value is signed in LSBs; clamp to the code range of the variant
	function automatic logic [13:0] arca_clamp(input logic [15:0] raw, input logic wide);
		logic signed [15:0] v;
		logic signed [15:0] hi;
		logic signed [15:0] lo;
		logic signed [15:0] r;
		v = signed'(raw);
		hi = wide ? 16'sh1FFF : 16'sh07FF;
		lo = wide ? -16'sh2000 : -16'sh0800;
		if (v > hi) begin
			r = hi;
		end else if (v < lo) begin
			r = lo;
		end else begin
			r = v;
		end
		arca_clamp = r[13:0];
	endfunction

	// Conversion results wait in a FIFO so a slow link does not stall the core
	logic fifo_in_valid;
	logic [13:0] fifo_in_data;
	logic fifo_out_valid;
	logic [13:0] fifo_out_data;
	logic fifo_out_ready;

	assign fifo_in_valid = i_raw_valid;
	assign fifo_in_data = arca_clamp(i_raw_value, wide_q);

	arca_fifo #(
		.WIDTH(ARCA_RES_W_14),
		.DEPTH(ARCA_FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_in_valid(fifo_in_valid),
		.i_in_data(fifo_in_data),
		.o_in_ready(o_raw_ready),
		.o_out_valid(fifo_out_valid),
		.o_out_data(fifo_out_data),
		.i_out_ready(fifo_out_ready)
	);

	// -----------------------------------------------------------------
	// Conversion cycle tracking
	// -----------------------------------------------------------------
	logic pending_q;
	logic clocked_q;
	logic fresh_q;

	// Clock activity since the last strobe decides add or restart
	// Decision is frozen at the strobe, since the live flag clears there
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pending_q <= 1'b0;
			clocked_q <= 1'b1;
			fresh_q <= 1'b1;
		end else if (cnv_rise) begin
			pending_q <= 1'b1;
			clocked_q <= 1'b0;
			fresh_q <= clocked_q || sclk_rise || sclk_fall;
		end else begin
			if (sclk_rise || sclk_fall) begin
				clocked_q <= 1'b1;
			end
			if (fifo_out_ready) begin
				pending_q <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// Accumulator
	// -----------------------------------------------------------------
	logic [23:0] acc_q;
	logic [10:0] cnt_q;
	logic [23:0] sample_ext;
	logic restart;

	arca_state_e state_q;

	assign sample_ext = wide_q ? {{10{fifo_out_data[13]}}, fifo_out_data}
		: {{12{fifo_out_data[11]}}, fifo_out_data[11:0]};
	// Load a finished result only while no shift is in progress
	assign fifo_out_ready = fifo_out_valid && pending_q && (state_q != ARCA_SHIFT);
	// Full count or any clock activity starts a fresh sum
	assign restart = fresh_q || (cnt_q == ARCA_MAX_SAMPLES);

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			acc_q <= ARCA_ACC_RST;
			cnt_q <= ARCA_CNT_RST;
		end else if (fifo_out_ready) begin
			if (restart) begin
				acc_q <= sample_ext;
				cnt_q <= 11'h001;
			end else begin
				acc_q <= acc_q + sample_ext;
				cnt_q <= cnt_q + 11'h001;
			end
		end
	end

	// -----------------------------------------------------------------
	// Serial shifter
	// -----------------------------------------------------------------
	logic [23:0] shift_q;
	logic [4:0] left_q;
	logic [4:0] tx_len;

	assign tx_len = arca_tx_len(cnt_q, wide_q);

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= ARCA_IDLE;
		end else begin
			case (state_q)
				ARCA_IDLE: begin
					if (fifo_out_ready) begin
						state_q <= ARCA_LOAD;
					end
				end
				ARCA_LOAD: begin
					state_q <= ARCA_SHIFT;
				end
				ARCA_SHIFT: begin
					if (cnv_rise || (sclk_fall && left_q == 5'h01)) begin
						state_q <= ARCA_IDLE;
					end
				end
				default: begin
					state_q <= ARCA_IDLE;
				end
			endcase
		end
	end

	// MSB first; held word is left-aligned so bit 23 is always on the pin
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			shift_q <= ARCA_ACC_RST;
			left_q <= ARCA_LEN_RST;
		end else if (state_q == ARCA_LOAD) begin
			shift_q <= acc_q << (5'(ARCA_ACC_W) - tx_len);
			left_q <= tx_len;
		end else if (state_q == ARCA_SHIFT && sclk_fall) begin
			shift_q <= {shift_q[22:0], 1'b0};
			left_q <= left_q - 5'h01;
		end
	end

	// -----------------------------------------------------------------
	// Registered outputs
	// -----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_sdo <= 1'b0;
			o_sdo_oe <= 1'b0;
			o_acc_count_max <= 1'b0;
		end else begin
			o_sdo <= shift_q[23];
			o_sdo_oe <= (state_q == ARCA_SHIFT) && !cnv_rise;
			o_acc_count_max <= (cnt_q == ARCA_MAX_SAMPLES);
		end
	end
endmodule

// [logic/arca_fifo.sv]
// Small valid/ready FIFO for conversion results
`timescale 1ns/10ps
module arca_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Fill side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// Drain side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full;
	logic empty;

	assign empty = (wr_q == rd_q);
	assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = mem[rd_q[AW-1:0]];

	always_ff @(posedge i_core_clk) begin
		if (i_in_valid && !full) begin
			mem[wr_q[AW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (i_in_valid && !full) begin
				wr_q <= wr_q + 1'b1;
			end
			if (i_out_ready && !empty) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

// [verification/arca_core_sva.sv]
// Checker for the result coding accumulator
`timescale 1ns/10ps
module arca_core_sva (
	// Design ports
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_wide_res,
	input wire logic i_raw_valid,
	input wire logic o_raw_ready,
	input wire logic i_convert_strobe,
	input wire logic i_sclk,
	input wire logic o_sdo,
	input wire logic o_sdo_oe,
	input wire logic o_acc_count_max
);
	logic [2:0] s_q;
	logic [2:0] c_q;
	logic [3:0] quiet_q;
	logic [3:0] cnv_q;
	logic [4:0] falls_q;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	// Pin edges resynchronised like the design does
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_q <= 3'h0;
			c_q <= 3'h0;
			quiet_q <= 4'h0;
			cnv_q <= 4'h0;
			falls_q <= 5'h00;
		end else begin
			s_q <= {s_q[1:0], i_sclk};
			c_q <= {c_q[1:0], i_convert_strobe};
			quiet_q <= (s_q[2] != s_q[1]) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
			cnv_q <= (c_q[1] && !c_q[2]) ? 4'h0 : cnv_q + {3'h0, cnv_q != 4'hF};
			falls_q <= !o_sdo_oe ? 5'h00 : falls_q + {4'h0, s_q[2] && !s_q[1]};
		end
	end
	sequence word_done;
		$fell(o_sdo_oe) ##0 (cnv_q == 4'hF);
	endsequence
	chk_reset_quiet: assert property (!$past(i_nrst) |-> !o_sdo_oe && !o_sdo && !o_acc_count_max)
		else $error("outputs active right after reset");
	chk_strobe_ends_word: assert property ($rose(i_convert_strobe) |-> ##[1:6] !o_sdo_oe)
		else $error("strobe did not end the word");
	chk_sdo_holds: assert property (quiet_q >= 4'h8 && cnv_q == 4'hF && o_sdo_oe && $past(o_sdo_oe) |-> $stable(o_sdo))
		else $error("data moved without a clock fall");
	chk_word_not_short: assert property (word_done |-> falls_q >= (i_wide_res ? 5'h0E : 5'h0C))
		else $error("word ended too early");
	chk_word_cap: assert property (o_sdo_oe |-> falls_q <= 5'h18)
		else $error("word longer than 24 bits");
	chk_ready_drop: assert property ($fell(o_raw_ready) |-> $past(i_raw_valid))
		else $error("ready fell without a push");
	chk_max_set_load: assert property ($rose(o_acc_count_max) |-> cnv_q <= 4'h8)
		else $error("count flag rose away from a conversion");
	chk_max_clear_load: assert property ($fell(o_acc_count_max) |-> cnv_q <= 4'h8)
		else $error("count flag fell away from a conversion");
endmodule
bind arca_core arca_core_sva arca_core_sva_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_wide_res(i_wide_res),
	.i_raw_valid(i_raw_valid), .o_raw_ready(o_raw_ready), .i_convert_strobe(i_convert_strobe), .i_sclk(i_sclk),
	.o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_acc_count_max(o_acc_count_max));

// [verification/arca_host_model.sv]
// Serial host model driving strobe and serial clock
`timescale 1ns/10ps
module arca_host_model (
	// Core clock, paces the strobe
	input wire logic i_clk,
	// Serial pins
	input wire logic i_sdo,
	output logic o_sclk,
	output logic o_strobe
);
	initial begin
		o_sclk = 1'b0; // Idle low outside frames
		o_strobe = 1'b0;
	end
	// Strobe rise starts a conversion, no clock in the cycle
	task automatic conv();
		@(posedge i_clk);
		o_strobe <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_strobe <= 1'b0;
		repeat (6) @(posedge i_clk);
	endtask
	// Capture on rise, device shifts on fall; pulses before next strobe discard
	task automatic read(input int n, output logic [23:0] w);
		w = 24'h000000;
		// Offset keeps every 62.5 ns step off a core clock edge
		@(posedge i_clk);
		#1.25;
		for (int k = 0; k < n; k++) begin
			#62.5 o_sclk = 1'b1;
			w = {w[22:0], i_sdo};
			#62.5 o_sclk = 1'b0;
		end
		#200;
	endtask
endmodule

// [verification/test_arca_core.sv]
// Testbench for the result coding accumulator
`timescale 1ns/10ps
module test_arca_core;
	logic i_core_clk, i_nrst, i_wide_res, i_raw_valid, o_raw_ready;
	logic i_convert_strobe, i_sclk, o_sdo, o_sdo_oe, o_acc_count_max;
	logic [15:0] i_raw_value;
	logic [23:0] got;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	int cur_w = 14;
	arca_core arca_core_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_wide_res(i_wide_res),
		.i_raw_valid(i_raw_valid), .i_raw_value(i_raw_value), .o_raw_ready(o_raw_ready),
		.i_convert_strobe(i_convert_strobe), .i_sclk(i_sclk), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
		.o_acc_count_max(o_acc_count_max));
	arca_host_model arca_host_model_i (.i_clk(i_core_clk), .i_sdo(o_sdo), .o_sclk(i_sclk),
		.o_strobe(i_convert_strobe));
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	// Hang guard, well above the two long summing runs
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 70000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [23:0] wrap(input int v, input int n);
		return 24'(v) & ((24'h000001 << n) - 24'h000001);
	endfunction
	task automatic do_reset(input logic wide);
		@(posedge i_core_clk);
		i_nrst <= 1'b0;
		i_wide_res <= wide;
		cur_w = wide ? 14 : 12;
		repeat (2) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_core_clk);
	endtask
	task automatic push(input int v);
		@(posedge i_core_clk);
		i_raw_valid <= 1'b1;
		i_raw_value <= 16'(v);
		@(posedge i_core_clk);
		while (o_raw_ready !== 1'b1) @(posedge i_core_clk);
		i_raw_valid <= 1'b0;
	endtask
	task automatic one(input int v);
		push(v);
		arca_host_model_i.conv();
	endtask
	task automatic t_code();
		int lo, hi, e;
		int v[7];
		lo = -(1 << (cur_w - 1));
		hi = -lo - 1;
		v = '{0, 1, -1, hi, hi + 99, lo, lo - 99};
		foreach (v[k]) begin
			e = v[k] > hi ? hi : (v[k] < lo ? lo : v[k]);
			one(v[k]);
			check("oe on", 24'h000001, {23'h000000, o_sdo_oe});
			arca_host_model_i.read(cur_w, got);
			check("code", wrap(e, cur_w), got);
			check("oe off", 24'h000000, {23'h000000, o_sdo_oe});
		end
	endtask
	task automatic t_discard();
		one(100);
		one(200);
		arca_host_model_i.read(1, got);
		one(-1);
		one(-1);
		arca_host_model_i.read(15, got);
		check("pair sum", wrap(-2, 15), got);
	endtask
	task automatic t_fifo();
		for (int k = 1; k <= 8; k++) push(-k);
		#1;
		check("ready full", 24'h000000, {23'h000000, o_raw_ready});
		for (int k = 1; k <= 8; k++) arca_host_model_i.conv();
		check("ready empty", 24'h000001, {23'h000000, o_raw_ready});
		arca_host_model_i.read(17, got);
		check("eight sum", wrap(-36, 17), got);
	endtask
	task automatic t_max();
		for (int k = 0; k < 1024; k++) one(8191);
		check("count max", 24'h000001, {23'h000000, o_acc_count_max});
		arca_host_model_i.read(24, got);
		check("full sum", 24'h7FFC00, got);
		for (int k = 0; k < 1024; k++) one(8191);
		one(5);
		check("count wrap", 24'h000000, {23'h000000, o_acc_count_max});
		arca_host_model_i.read(14, got);
		check("restart", 24'h000005, got);
	endtask
	initial begin
		i_nrst = 1'b0;
		i_wide_res = 1'b1;
		i_raw_valid = 1'b0;
		i_raw_value = 16'h0000;
		do_reset(1'b1);
		t_code();
		t_discard();
		t_fifo();
		t_max();
		do_reset(1'b0);
		t_code();
		wrap_up();
	end
endmodule
